// *** bpc_pkg.sv ***
package bpc_pkg;
    // Register map (byte addresses on the serial port)
    localparam logic [7:0] VOUT2_SEL_ADDR     = 8'h01;
    localparam logic [7:0] CH1_CMD_ADDR       = 8'h03;
    localparam logic [7:0] CH2_CMD_ADDR       = 8'h04;
    localparam logic [7:0] CH3_CMD_ADDR       = 8'h05;
    localparam logic [7:0] SYSTEM_STATUS_ADDR = 8'h06;
    localparam logic [7:0] REG_RESET          = 8'h00;
    // Command register fields
    localparam int CMD_DISABLE_BIT            = 0;
    localparam int CMD_FORCE_CONT_BIT         = 1;
    // Status register fields
    localparam int STAT_PG_LSB                = 0;
    localparam int STAT_OTW_BIT               = 3;
    localparam int STAT_OC_LSB                = 4;
    localparam int STAT_OTP_BIT               = 7;
    // Hiccup timing in switching cycles
    localparam logic [13:0] HICCUP_WAIT_CYC   = 14'h0100;
    localparam logic [13:0] HICCUP_OFF_CYC    = 14'h2000;
    // Resistor-mode fallback frequency and period at the system clock
    localparam int SYS_CLK_KHZ                = 10000;
    localparam int FALLBACK_KHZ               = 100;
    localparam logic [7:0] FALLBACK_PERIOD    = 8'(SYS_CLK_KHZ / FALLBACK_KHZ);
    // Cycles of fallback before handing back to the resistor oscillator
    localparam logic [7:0] FALLBACK_CYCLES    = 8'h10;
    // Target address default, value arbitrary
    localparam logic [6:0] TARGET_ADDR_DEF    = 7'h2A;
endpackage : bpc_pkg

// *** bpc_sync.sv ***
`timescale 1ns/10ps
module bpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bpc_sync_t;
    bpc_sync_t st_reg;
    bpc_sync_t st_next;

    always_comb begin
        st_next.meta   = i_async;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.stable;
endmodule : bpc_sync

// *** bpc_i2c_target.sv ***
`timescale 1ns/10ps
module bpc_i2c_target (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    // Synchronised bus lines
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [6:0] i_target_addr,
    input  wire logic       i_accept,
    // Data line drive
    output logic            o_sda_oe,
    // Register write strobe
    output logic            o_wr_stb,
    output logic [7:0]      o_wr_addr,
    output logic [7:0]      o_wr_data
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DEV  = 5'b00010,
        ST_REG  = 5'b00100,
        ST_DATA = 5'b01000,
        ST_ACK  = 5'b10000
    } bpc_i2c_state_t;

    typedef struct packed {
        bpc_i2c_state_t state;
        bpc_i2c_state_t after_ack;
        logic           scl_d;
        logic           sda_d;
        logic [3:0]     bits;
        logic [7:0]     shift;
        logic [7:0]     addr;
        logic           sda_oe;
        logic           wr_stb;
        logic [7:0]     wr_data;
    } bpc_i2c_t;
    bpc_i2c_t st_reg;
    bpc_i2c_t st_next;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] shifted;

    always_comb begin
        scl_rise   = i_scl & ~st_reg.scl_d;
        scl_fall   = ~i_scl & st_reg.scl_d;
        start_cond = i_scl & st_reg.scl_d & st_reg.sda_d & ~i_sda;
        stop_cond  = i_scl & st_reg.scl_d & ~st_reg.sda_d & i_sda;
        shifted    = {st_reg.shift[6:0], i_sda};
        st_next        = st_reg;
        st_next.scl_d  = i_scl;
        st_next.sda_d  = i_sda;
        st_next.wr_stb = 1'b0;
        if (start_cond) begin
            st_next.state  = ST_DEV;
            st_next.bits   = 4'h0;
            st_next.sda_oe = 1'b0;
        end else if (stop_cond) begin
            st_next.state  = ST_IDLE;
            st_next.sda_oe = 1'b0;
        end else begin
            case (st_reg.state)
                ST_DEV, ST_REG, ST_DATA: begin
                    if (scl_rise) begin
                        st_next.shift = shifted;
                        st_next.bits  = st_reg.bits + 4'h1;
                    end
                    if (scl_fall && st_reg.bits == 4'h8) begin
                        st_next.bits = 4'h0;
                        st_next.state = ST_ACK;
                        st_next.sda_oe = 1'b1;
                        case (st_reg.state)
                            ST_DEV: begin
                                // 7-bit write address only; general call never matches
                                if (st_reg.shift != {i_target_addr, 1'b0} || !i_accept) begin
                                    st_next.state  = ST_IDLE;
                                    st_next.sda_oe = 1'b0;
                                end
                                st_next.after_ack = ST_REG;
                            end
                            ST_REG: begin
                                st_next.addr      = st_reg.shift;
                                st_next.after_ack = ST_DATA;
                            end
                            default: begin
                                // Commit on the falling edge closing the last bit
                                st_next.wr_stb    = 1'b1;
                                st_next.wr_data   = st_reg.shift;
                                st_next.after_ack = ST_DATA;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Hold low across the whole ninth clock high phase
                    if (scl_fall) begin
                        st_next.sda_oe = 1'b0;
                        st_next.state  = st_reg.after_ack;
                        if (st_reg.after_ack == ST_DATA && st_reg.state == ST_ACK && st_reg.wr_data == st_reg.wr_data) begin
                            st_next.addr = st_reg.addr;
                        end
                    end
                end
                default: begin
                    st_next.state  = ST_IDLE;
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '{state: ST_IDLE, after_ack: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sda_oe  = st_reg.sda_oe;
    assign o_wr_stb  = st_reg.wr_stb;
    assign o_wr_addr = st_reg.addr;
    assign o_wr_data = st_reg.wr_data;
endmodule : bpc_i2c_target

// *** bpc_top.sv ***
// How it works
// - Peak current at reference ends high-side pulse
// - Low-side source overlimit skips next high-side pulse
// - High-side resumes once source current is below
// - Sink overlimit turns both switches off until cycle
// - Overload past 256 cycles: off for 8192
// - Power ok released when all channels in window
// - Power ok low outside 92.5 to 107.5 percent
// - Power ok low in lockout, thermal, disable, softstart
// - Status bits 2:0 show per-channel regulation
// - Sync mode starts cycles on clock falling edge
// - First high level enters sync mode, pin released
// - Clock loss: fallback 100 kHz then resistor rate
// - Stop above 160 C, restart below 140 C
// - Serial target for 100 and 400 kbps
// - Seven-bit addressing only, no general call
// - Acknowledge each byte on ninth clock high
// - Data committed on last bit falling edge
// - All enable pins low blocks serial updates
// - Registers kept while supply above 3.8 V and out of reset
// - Command bit one forces continuous switching
`timescale 1ns/10ps
module bpc_top #(
    parameter logic [6:0] TARGET_ADDR = bpc_pkg::TARGET_ADDR_DEF
) (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    // Analog comparator results per channel
    input  wire logic [2:0] i_peak_at_ref,
    input  wire logic [2:0] i_ls_source_over,
    input  wire logic [2:0] i_ls_sink_over,
    input  wire logic [2:0] i_overload,
    input  wire logic [2:0] i_fb_above_95,
    input  wire logic [2:0] i_fb_above_925,
    input  wire logic [2:0] i_fb_below_105,
    input  wire logic [2:0] i_fb_below_1075,
    input  wire logic [2:0] i_soft_start_done,
    // Supply and temperature supervision
    input  wire logic       i_uvlo,
    input  wire logic       i_temp_over_160,
    input  wire logic       i_temp_below_140,
    input  wire logic       i_supply_above_3v8,
    // Enable pins
    input  wire logic       i_channel_one_enable_pin,
    input  wire logic       i_channel_two_enable_pin,
    input  wire logic       i_channel_three_enable_pin,
    // Frequency set pin and resistor oscillator
    input  wire logic       i_freq_set_clock_in,
    input  wire logic       i_freq_set_high,
    input  wire logic       i_resistor_osc_tick,
    output logic            o_freq_set_release,
    // Serial bus
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    // Switch drive and status
    output logic [2:0]      o_hs_on,
    output logic [2:0]      o_ls_on,
    output logic [2:0]      o_pulse_skip_operation,
    output logic [2:0]      o_channel_run,
    output logic [2:0]      o_cycle_start,
    output logic            o_power_ok_out_oe,
    output logic [7:0]      o_system_status
);
    typedef struct packed {
        logic        sync_mode;
        logic        osc_low_d;
        logic        fallback;
        logic [7:0]  fb_div;
        logic [7:0]  fb_cycles;
        logic        cycle;
        logic [2:0]  hs;
        logic [2:0]  ls;
        logic [2:0]  skip;
        logic [2:0]  sink_off;
        logic [2:0]  hiccup;
        logic [41:0] hic_cnt;
        logic [2:0]  in_reg;
        logic        thermal;
        logic        pok_low;
        logic [7:0]  vout2_sel;
        logic [7:0]  cmd1;
        logic [7:0]  cmd2;
        logic [7:0]  cmd3;
        logic [7:0]  status;
        logic [2:0]  cycle_out;
        logic [2:0]  run;
    } bpc_top_t;
    bpc_top_t st_reg;
    bpc_top_t st_next;

    // Pin inputs crossing into the system clock
    logic [17:0] raw_pins;
    logic [17:0] pins;
    assign raw_pins = {i_freq_set_clock_in, i_freq_set_high, i_channel_one_enable_pin,
                       i_channel_two_enable_pin, i_channel_three_enable_pin, i_scl, i_sda,
                       i_uvlo, i_temp_over_160, i_temp_below_140, i_supply_above_3v8,
                       i_resistor_osc_tick, i_soft_start_done, i_overload[2:0]};
    bpc_sync #(.WIDTH(18)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_async   (raw_pins),
        .o_sync    (pins)
    );

    logic       osc_clk_s;
    logic       freq_high_s;
    logic [2:0] en_pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       uvlo_s;
    logic       t_over_s;
    logic       t_below_s;
    logic       supply_ok_s;
    logic       freq_set_clock_in_tick_s;
    logic [2:0] ss_done_s;
    logic [2:0] overload_s;
    assign {osc_clk_s, freq_high_s, en_pins_s, scl_s, sda_s, uvlo_s, t_over_s, t_below_s,
            supply_ok_s, freq_set_clock_in_tick_s, ss_done_s, overload_s} = pins;

    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       sda_oe;
    logic [2:0] en_pins_rev;
    assign en_pins_rev = {en_pins_s[0], en_pins_s[1], en_pins_s[2]};

    bpc_i2c_target u_i2c (
        .i_sys_clk     (i_sys_clk),
        .i_resetn      (i_resetn),
        .i_scl         (scl_s),
        .i_sda         (sda_s),
        .i_target_addr (TARGET_ADDR),
        .i_accept      (|en_pins_s),
        .o_sda_oe      (sda_oe),
        .o_wr_stb      (wr_stb),
        .o_wr_addr     (wr_addr),
        .o_wr_data     (wr_data)
    );

    logic [2:0] disable_bits;
    logic [2:0] ch_enabled;
    logic [2:0] win_in;
    logic [2:0] win_out;
    logic       osc_fall;

    always_comb begin
        st_next = st_reg;
        disable_bits = {st_reg.cmd3[bpc_pkg::CMD_DISABLE_BIT], st_reg.cmd2[bpc_pkg::CMD_DISABLE_BIT],
                        st_reg.cmd1[bpc_pkg::CMD_DISABLE_BIT]};
        ch_enabled = en_pins_rev & ~disable_bits;
        st_next.osc_low_d = ~osc_clk_s;
        osc_fall = osc_clk_s == 1'b0 && st_reg.osc_low_d == 1'b0;
        // Switching clock source
        if (!st_reg.sync_mode && freq_high_s) begin
            st_next.sync_mode = 1'b1;
        end
        st_next.cycle = 1'b0;
        if (st_reg.sync_mode && !st_reg.fallback) begin
            st_next.cycle = osc_fall;
            st_next.fb_div = st_reg.fb_div + 8'h01;
            if (osc_fall) begin
                st_next.fb_div = 8'h00;
            end else if (st_reg.fb_div == 8'hFF) begin
                // External clock gone: run at fallback rate a while
                st_next.fallback  = 1'b1;
                st_next.fb_cycles = 8'h00;
                st_next.fb_div    = 8'h00;
            end
        end else if (st_reg.fallback) begin
            st_next.fb_div = st_reg.fb_div + 8'h01;
            if (st_reg.fb_div == bpc_pkg::FALLBACK_PERIOD - 8'h01) begin
                st_next.fb_div    = 8'h00;
                st_next.cycle     = 1'b1;
                st_next.fb_cycles = st_reg.fb_cycles + 8'h01;
                if (st_reg.fb_cycles == bpc_pkg::FALLBACK_CYCLES - 8'h01) begin
                    st_next.fallback  = 1'b0;
                    st_next.sync_mode = 1'b0;
                end
            end
        end else begin
            st_next.cycle = freq_set_clock_in_tick_s;
        end
        // Thermal shutdown with hysteresis
        if (t_over_s) begin
            st_next.thermal = 1'b1;
        end else if (t_below_s) begin
            st_next.thermal = 1'b0;
        end
        // Per-channel switch control
        for (int c = 0; c < 3; c++) begin
            st_next.run[c] = ch_enabled[c] & ~st_reg.thermal & ~uvlo_s & ~st_reg.hiccup[c];
            if (st_reg.cycle) begin
                if (st_reg.hiccup[c]) begin
                    st_next.hic_cnt[c*14 +: 14] = st_reg.hic_cnt[c*14 +: 14] + 14'h0001;
                    if (st_reg.hic_cnt[c*14 +: 14] == bpc_pkg::HICCUP_OFF_CYC - 14'h0001) begin
                        st_next.hiccup[c] = 1'b0;
                        st_next.hic_cnt[c*14 +: 14] = 14'h0000;
                    end
                end else if (overload_s[c]) begin
                    st_next.hic_cnt[c*14 +: 14] = st_reg.hic_cnt[c*14 +: 14] + 14'h0001;
                    if (st_reg.hic_cnt[c*14 +: 14] == bpc_pkg::HICCUP_WAIT_CYC) begin
                        st_next.hiccup[c] = 1'b1;
                        st_next.hic_cnt[c*14 +: 14] = 14'h0000;
                    end
                end else begin
                    st_next.hic_cnt[c*14 +: 14] = 14'h0000;
                end
                st_next.sink_off[c] = 1'b0;
                // Sourcing over limit at cycle boundary keeps low side on
                st_next.skip[c] = i_ls_source_over[c];
                st_next.hs[c] = st_reg.run[c] & ~i_ls_source_over[c];
                st_next.ls[c] = st_reg.run[c] & i_ls_source_over[c];
            end else if (st_reg.hs[c] && i_peak_at_ref[c]) begin
                st_next.hs[c] = 1'b0;
                st_next.ls[c] = ~st_reg.sink_off[c];
            end
            if (st_reg.ls[c] && i_ls_sink_over[c]) begin
                st_next.ls[c] = 1'b0;
                st_next.hs[c] = 1'b0;
                st_next.sink_off[c] = 1'b1;
            end
            if (!st_reg.run[c]) begin
                st_next.hs[c] = 1'b0;
                st_next.ls[c] = 1'b0;
            end
        end
        st_next.cycle_out = {3{st_reg.cycle}};
        // Power-good window with hysteresis
        win_in  = i_fb_above_95 & i_fb_below_105;
        win_out = ~i_fb_above_925 | ~i_fb_below_1075;
        for (int c = 0; c < 3; c++) begin
            if (win_out[c]) begin
                st_next.in_reg[c] = 1'b0;
            end else if (win_in[c]) begin
                st_next.in_reg[c] = 1'b1;
            end
        end
        st_next.pok_low = ~&st_reg.in_reg | uvlo_s | st_reg.thermal
                        | ~&en_pins_s | ~&ss_done_s;
        st_next.status = {st_reg.thermal, st_reg.hiccup, t_over_s, st_reg.in_reg};
        // Register writes
        if (wr_stb) begin
            case (wr_addr)
                bpc_pkg::VOUT2_SEL_ADDR: st_next.vout2_sel = wr_data;
                bpc_pkg::CH1_CMD_ADDR:   st_next.cmd1 = wr_data;
                bpc_pkg::CH2_CMD_ADDR:   st_next.cmd2 = wr_data;
                bpc_pkg::CH3_CMD_ADDR:   st_next.cmd3 = wr_data;
                default: ;
            endcase
        end
        // Contents survive anything short of reset or supply falling below 3.8 V
        if (!supply_ok_s) begin
            st_next.vout2_sel = bpc_pkg::REG_RESET;
            st_next.cmd1 = bpc_pkg::REG_RESET;
            st_next.cmd2 = bpc_pkg::REG_RESET;
            st_next.cmd3 = bpc_pkg::REG_RESET;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_hs_on                = st_reg.hs;
    assign o_ls_on                = st_reg.ls;
    assign o_pulse_skip_operation = ~{st_reg.cmd3[bpc_pkg::CMD_FORCE_CONT_BIT],
                                      st_reg.cmd2[bpc_pkg::CMD_FORCE_CONT_BIT],
                                      st_reg.cmd1[bpc_pkg::CMD_FORCE_CONT_BIT]};
    assign o_channel_run          = st_reg.run;
    assign o_cycle_start          = st_reg.cycle_out;
    assign o_freq_set_release     = st_reg.sync_mode;
    assign o_sda_out              = 1'b0;
    assign o_sda_oe               = sda_oe;
    assign o_power_ok_out_oe      = st_reg.pok_low;
    assign o_system_status        = st_reg.status;
endmodule : bpc_top

// *** bpc_top_props.sv ***
`timescale 1ns/10ps
module bpc_top_props (
    // Clock and reset
    input wire logic       i_sys_clk,
    input wire logic       i_resetn,
    // Watched inputs
    input wire logic [2:0] i_peak_at_ref,
    input wire logic [2:0] i_ls_source_over,
    input wire logic [2:0] i_ls_sink_over,
    input wire logic [2:0] i_fb_above_925,
    input wire logic [2:0] i_fb_below_1075,
    input wire logic       i_temp_over_160,
    input wire logic       i_freq_set_high,
    input wire logic       i_scl,
    // Watched outputs
    input wire logic       o_sda_oe,
    input wire logic [2:0] o_hs_on,
    input wire logic [2:0] o_ls_on,
    input wire logic [2:0] o_channel_run,
    input wire logic [2:0] o_cycle_start,
    input wire logic       o_freq_set_release,
    input wire logic       o_power_ok_out_oe
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    chk_peak_ends_hs:
    assert property (o_hs_on[0] && o_channel_run[0] && i_peak_at_ref[0] && !o_cycle_start[0] && !i_ls_sink_over[0]
        |=> !o_hs_on[0] && o_ls_on[0]) else $error("high side not ended at peak");
    chk_source_skip:
    assert property (o_cycle_start[0] && i_ls_source_over[0] && $past(i_ls_source_over[0]) |=> !o_hs_on[0])
        else $error("high side not skipped");
    chk_hs_resume:
    assert property (o_cycle_start[0] && o_channel_run[0] && $past(o_channel_run[0]) && !i_ls_source_over[0]
        && !$past(i_ls_source_over[0]) && !i_peak_at_ref[0] && !i_ls_sink_over[0] |=> o_hs_on[0])
        else $error("high side not resumed");
    chk_sink_off:
    assert property (o_ls_on[0] && i_ls_sink_over[0] && !o_cycle_start[0] |=> !o_ls_on[0] && !o_hs_on[0])
        else $error("switches not off at sink limit");
    chk_pok_window:
    assert property ((!(&i_fb_above_925 && &i_fb_below_1075))[*2] |=> o_power_ok_out_oe)
        else $error("power ok not pulled low");
    chk_thermal_stop:
    assert property (i_temp_over_160[*5] |=> o_channel_run == 3'h0 && o_hs_on == 3'h0)
        else $error("switching not stopped when hot");
    chk_sync_entry:
    assert property (i_freq_set_high[*3] |=> o_freq_set_release) else $error("sync mode not entered");
    chk_ack_hold:
    assert property ($rose(i_scl) && o_sda_oe |=> o_sda_oe[*3]) else $error("ack dropped in clock high");
    cov_sync: cover property ($rose(o_freq_set_release));
    cov_ack: cover property ($rose(o_sda_oe));
    cov_skip: cover property (o_cycle_start[0] && i_ls_source_over[0]);
endmodule : bpc_top_props
bind bpc_top bpc_top_props u_props (.*);

// *** bpc_ctrl_model.sv ***
`timescale 1ns/10ps
module bpc_ctrl_model (
    // Clock and data line level
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    // Clock drive and data pull-down
    output logic      o_scl = 1'h1,
    output logic      o_sda_low = 1'h0
);
    // Quarter bit of 200 ns keeps one bit at 800 ns
    task automatic q(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : q
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low = !b[i];
            q(2);
            o_scl = 1'h1;
            q(4);
            o_scl = 1'h0;
            q(2);
        end
        o_sda_low = 1'h0;
        q(2);
        o_scl = 1'h1;
        q(2);
        ack = !i_sda;
        q(2);
        o_scl = 1'h0;
        q(2);
    endtask : put
    task automatic write(input logic [6:0] a, input logic [7:0] r, d, output int acks);
        logic k0, k1, k2;
        o_sda_low = 1'h1;
        q(4);
        o_scl = 1'h0;
        q(2);
        put({a, 1'h0}, k0);
        put(r, k1);
        put(d, k2);
        o_sda_low = 1'h1;
        q(2);
        o_scl = 1'h1;
        q(2);
        o_sda_low = 1'h0;
        q(8);
        acks = k0 + k1 + k2;
    endtask : write
endmodule : bpc_ctrl_model

// *** bpc_top_tb.sv ***
`timescale 1ns/10ps
module bpc_top_tb;
    logic       i_sys_clk = 1'h0, i_resetn = 1'h0, i_uvlo = 1'h0, i_temp_over_160 = 1'h0, i_temp_below_140 = 1'h1;
    logic       i_supply_above_3v8 = 1'h1, i_freq_set_clock_in = 1'h0, i_resistor_osc_tick = 1'h0;
    logic       i_channel_one_enable_pin = 1'h1, i_channel_two_enable_pin = 1'h1, i_channel_three_enable_pin = 1'h1;
    logic       i_scl, sda_low, o_freq_set_release, o_sda_out, o_sda_oe, o_power_ok_out_oe, tick_en = 1'h1;
    logic [2:0] i_peak_at_ref = 3'h0, i_ls_source_over = 3'h0, i_ls_sink_over = 3'h0, i_overload = 3'h0;
    logic [2:0] i_fb_above_95 = 3'h7, i_fb_above_925 = 3'h7, i_fb_below_105 = 3'h7, i_fb_below_1075 = 3'h7;
    logic [2:0] i_soft_start_done = 3'h7, o_hs_on, o_ls_on, o_pulse_skip_operation, o_channel_run, o_cycle_start;
    logic [7:0] o_system_status, cmd [3] = '{8'h00, 8'h00, 8'h00};
    logic [5:0] f;
    logic [6:0] bad [3] = '{bpc_pkg::TARGET_ADDR_DEF ^ 7'h01, 7'h00, 7'h78};
    int         n_errors = 0, n_compared = 0, tick_per = 20, fclk_en = 0, acks, g;
    wire        i_freq_set_high = i_freq_set_clock_in;
    wire        i_sda = !(sda_low || (o_sda_oe && !o_sda_out));
    wire [2:0]  en = {i_channel_three_enable_pin, i_channel_two_enable_pin, i_channel_one_enable_pin};
    bpc_top uut (.*);
    bpc_ctrl_model ctl (.i_sys_clk(i_sys_clk), .i_sda(i_sda), .o_scl(i_scl), .o_sda_low(sda_low));
    initial forever #50 i_sys_clk = !i_sys_clk;
    initial forever begin
        repeat (tick_per - 1) @(posedge i_sys_clk);
        #1 i_resistor_osc_tick = tick_en;
        repeat (1) @(posedge i_sys_clk);
        #1 i_resistor_osc_tick = 1'h0;
    end
    initial forever begin
        repeat (5) @(posedge i_sys_clk);
        #1 i_freq_set_clock_in = fclk_en[0];
        repeat (5) @(posedge i_sys_clk);
        #1 i_freq_set_clock_in = 1'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : step
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic check(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_cs(output int gap);
        gap = 0;
        do begin
            step(1);
            gap++;
        end while (o_cycle_start[0] !== 1'h1 && gap < 400);
        if (gap >= 400) begin
            n_errors++;
            results();
        end
    endtask : wait_cs
    task automatic wr(input logic [6:0] a, input logic [7:0] r, d);
        logic [2:0] pe, re;
        logic       ok;
        ok = a === bpc_pkg::TARGET_ADDR_DEF && |en;
        ctl.write(a, r, d, acks);
        check("acks", ok ? 16'h3 : 16'h0, 16'(acks));
        if (ok && r >= 8'h03 && r <= 8'h05)
            cmd[r - 8'h03] = d;
        for (int i = 0; i < 3; i++) begin
            pe[i] = !cmd[i][1];
            re[i] = en[i] && !cmd[i][0];
        end
        check("skip", 16'(pe), 16'(o_pulse_skip_operation));
        check("run", 16'(re), 16'(o_channel_run));
    endtask : wr
    initial begin
        void'($urandom(5));
        step(12);
        i_resetn = 1'h1;
        step(3);
        foreach (bad[k]) wr(bad[k], 8'h03, 8'h03);
        repeat (8) wr(bpc_pkg::TARGET_ADDR_DEF, 8'(3 + $urandom % 5), 8'($urandom));
        {i_channel_three_enable_pin, i_channel_two_enable_pin, i_channel_one_enable_pin} = 3'h0;
        step(4);
        wr(bpc_pkg::TARGET_ADDR_DEF, 8'h03, 8'h02);
        {i_channel_three_enable_pin, i_channel_two_enable_pin, i_channel_one_enable_pin} = 3'h7;
        step(4);
        for (int i = 3; i < 6; i++) wr(bpc_pkg::TARGET_ADDR_DEF, 8'(i), 8'h00);
        $display("done serial");
        wait_cs(g);
        step(1);
        check("drive0", 16'h2, 16'({o_hs_on[0], o_ls_on[0]}));
        i_peak_at_ref[0] = 1'h1;
        step(1);
        check("drive0", 16'h1, 16'({o_hs_on[0], o_ls_on[0]}));
        i_peak_at_ref[0] = 1'h0;
        i_ls_sink_over[0] = 1'h1;
        step(1);
        check("drive0", 16'h0, 16'({o_hs_on[0], o_ls_on[0]}));
        i_ls_sink_over[0] = 1'h0;
        step(5);
        check("drive0", 16'h0, 16'({o_hs_on[0], o_ls_on[0]}));
        i_ls_source_over[0] = 1'h1;
        wait_cs(g);
        wait_cs(g);
        step(1);
        check("drive0", 16'h1, 16'({o_hs_on[0], o_ls_on[0]}));
        i_ls_source_over[0] = 1'h0;
        wait_cs(g);
        step(1);
        check("drive0", 16'h2, 16'({o_hs_on[0], o_ls_on[0]}));
        $display("done switching");
        for (int k = 0; k < 12; k++) begin
            f = k[0] ? 6'h00 : 6'h01 << (k / 2);
            i_uvlo = f[0];
            i_channel_two_enable_pin = !f[1];
            i_soft_start_done[2] = !f[2];
            i_fb_above_95[1] = !f[3];
            i_fb_above_925[1] = !f[3];
            i_fb_below_105[0] = !f[4];
            i_fb_below_1075[0] = !f[4];
            i_temp_over_160 = f[5];
            i_temp_below_140 = !f[5];
            step(20);
            check("pok low", 16'(|f), 16'(o_power_ok_out_oe));
            check("run", (f[0] || f[5]) ? 16'h0 : {13'h0, 1'h1, !f[1], 1'h1}, 16'(o_channel_run));
            if (f[2:0] == 3'h0 && !f[5])
                check("in reg", {13'h0, 1'h1, !f[3], !f[4]}, 16'(o_system_status[2:0]));
        end
        $display("done power ok");
        tick_en = 1'h0;
        fclk_en = 1;
        step(40);
        check("sync mode", 16'h1, 16'(o_freq_set_release));
        wait_cs(g);
        wait_cs(g);
        check("sync gap", 16'h000a, 16'(g));
        fclk_en = 0;
        step(400);
        wait_cs(g);
        wait_cs(g);
        check("fallback gap", 16'h0064, 16'(g));
        tick_en = 1'h1;
        tick_per = 4;
        step(2000);
        $display("done clocking");
        i_overload[0] = 1'h1;
        step(1000);
        check("run0", 16'h1, 16'(o_channel_run[0]));
        step(72);
        check("hiccup", 16'h1, 16'({o_channel_run[0], o_system_status[bpc_pkg::STAT_OC_LSB]}));
        i_overload[0] = 1'h0;
        step(32528);
        check("run0", 16'h0, 16'(o_channel_run[0]));
        step(360);
        check("run0", 16'h1, 16'(o_channel_run[0]));
        $display("done hiccup");
        results();
    end
endmodule : bpc_top_tb
